/* File: hw/fhs_params.svh */
`ifndef FHS_PARAMS_SVH
`define FHS_PARAMS_SVH

// register select codes
`define FHS_REG_CMD_STAT 2'h0
`define FHS_REG_TRACK    2'h1
`define FHS_REG_SECTOR   2'h2
`define FHS_REG_DATA     2'h3

// status bit positions
`define FHS_ST_BUSY  0
`define FHS_ST_DRQ   1
`define FHS_ST_INDEX 1
`define FHS_ST_LOST  2
`define FHS_ST_TRK0  2
`define FHS_ST_CRC   3
`define FHS_ST_SEEK  4
`define FHS_ST_HEAD  5

// command field positions
`define FHS_CMD_VERIFY  2
`define FHS_CMD_ENGAGE  2
`define FHS_CMD_HEADLD  3
`define FHS_CMD_UPDATE  4
`define FHS_CMD_WRITE   5
`define FHS_CMD_IMMED   3
`define FHS_CMD_ONINDEX 2
`define FHS_CMD_FORCE   4'hD
`define FHS_CMD_RESTORE 4'h0
`define FHS_CMD_SEEK    4'h1

// reset and preset values
`define FHS_RST_TRACK  8'h00
`define FHS_CRC_PRESET 16'hFFFF
`define FHS_CRC_POLY   16'h1021

// counts
`define FHS_SECTOR_BYTES 8'h80
`define FHS_ID_BYTES     8'h07
`define FHS_ID_TRACK_POS 8'h01
`define FHS_RESTORE_MAX  8'hFF
`define FHS_UNLOAD_IDX   2'h3
`define FHS_VERIFY_IDX   2'h2

// timing
`define FHS_CLK_MHZ          100
`define FHS_T_DIR_SETUP_US   24
`define FHS_T_STEP_PULSE_US  4
`define FHS_T_STEP_6_MS      6
`define FHS_T_STEP_10_MS     10
`define FHS_T_STEP_20_MS     20
`define FHS_T_STEP_TEST_US   400
`define FHS_T_SETTLE_MS      10
`define FHS_T_HEAD_MS        10
`define FHS_CYC_DIR_SETUP    (`FHS_T_DIR_SETUP_US * `FHS_CLK_MHZ)
`define FHS_CYC_STEP_PULSE   (`FHS_T_STEP_PULSE_US * `FHS_CLK_MHZ)
`define FHS_CYC_STEP_6       (`FHS_T_STEP_6_MS * 1000 * `FHS_CLK_MHZ)
`define FHS_CYC_STEP_10      (`FHS_T_STEP_10_MS * 1000 * `FHS_CLK_MHZ)
`define FHS_CYC_STEP_20      (`FHS_T_STEP_20_MS * 1000 * `FHS_CLK_MHZ)
`define FHS_CYC_STEP_TEST    (`FHS_T_STEP_TEST_US * `FHS_CLK_MHZ)
`define FHS_CYC_SETTLE       (`FHS_T_SETTLE_MS * 1000 * `FHS_CLK_MHZ)
`define FHS_CYC_HEAD         (`FHS_T_HEAD_MS * 1000 * `FHS_CLK_MHZ)

`endif

/* File: hw/fhs_pkg.sv */
package fhs_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_DIR    = 3'h1,
    ST_PULSE  = 3'h3,
    ST_WAIT   = 3'h2,
    ST_SETTLE = 3'h6,
    ST_HLD    = 3'h7,
    ST_VERIFY = 3'h5,
    ST_XFER   = 3'h4
  } fhs_fsm_e;

  typedef struct packed {
    logic       csN;
    logic       rdN;
    logic       wrN;
    logic [1:0] sel;
    logic [7:0] data;
    logic       tick;
    logic       rdat;
    logic       index;
    logic       motorType;
    logic       test;
    logic       engagedN;
    logic       trackZeroN;
  } fhs_pins_s;

  typedef struct packed {
    fhs_pins_s   s1;
    fhs_pins_s   s2;
    fhs_pins_s   prev;
    fhs_fsm_e    state;
    logic [7:0]  cmd;
    logic [7:0]  track;
    logic [7:0]  sector;
    logic [7:0]  data;
    logic [7:0]  shift;
    logic [7:0]  byteCnt;
    logic [7:0]  stepCnt;
    logic [15:0] crc;
    logic [21:0] cnt;
    logic [2:0]  bitCnt;
    logic [1:0]  phase;
    logic [1:0]  unloadIdx;
    logic [1:0]  verIdx;
    logic        dirIn;
    logic        stepPulse;
    logic        headLoad;
    logic        busy;
    logic        byte_request;
    logic        irq;
    logic        lost;
    logic        crcErr;
    logic        seekErr;
    logic        idxArm;
    logic        wrStarted;
    logic        idMatch;
    logic [7:0]  busOut;
    logic        busOe;
    logic        wrBit;
    logic        phA;
    logic        phB;
    logic        phC;
  } fhs_state_s;

endpackage : fhs_pkg

/* File: hw/fhs_top.sv */
`include "fhs_params.svh"

// What this block does
// - select code picks status/command, track, sector, data
// - drive bus only on select plus read
// - command write-only, status read-only, meaning varies
// - command while busy aborts and interrupts
// - track counts up stepping in, down out
// - seek target comes from data register
// - read byte raises request, data read clears
// - unread byte overwritten sets lost data
// - write request on transfer, zero byte if late
// - interrupt on end, error, lost, force
// - ccitt crc preset ones from address mark
// - step period from rate field and strap
// - ten millisecond settle after last step
// - three phase sequence, phase one after reset
// - step/direction mode: pulse and direction pins
// - direction settled before step pulse
// - verify track number and crc after settle
// - verify mismatch sets seek error
// - head load until third idle index
// - head engage delay then sample engaged input
// - engage flag clear skips head delay
// - busy while executing, cleared on completion
module fhs_top
  import fhs_pkg::*;
#(
  parameter int unsigned StepCyc6    = `FHS_CYC_STEP_6,
  parameter int unsigned StepCyc10   = `FHS_CYC_STEP_10,
  parameter int unsigned StepCyc20   = `FHS_CYC_STEP_20,
  parameter int unsigned StepCycTest = `FHS_CYC_STEP_TEST,
  parameter int unsigned SettleCyc   = `FHS_CYC_SETTLE,
  parameter int unsigned HeadCyc     = `FHS_CYC_HEAD
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       chipSelectN,
  input  wire logic       readStrobeN,
  input  wire logic       writeStrobeN,
  input  wire logic [1:0] regSelect,
  input  wire logic [7:0] hostBusLinesIn,
  output wire logic [7:0] hostBusLinesOut,
  output wire logic       hostBusLinesOe,
  output wire logic       byteRequest,
  output wire logic       irqOut,
  input  wire logic       diskReadSerial,
  input  wire logic       diskBitTick,
  output wire logic       diskWriteSerial,
  input  wire logic       indexPulse,
  input  wire logic       trackZeroN,
  input  wire logic       motorTypeSel,
  input  wire logic       testStrap,
  output wire logic       motorPhaseA,
  output wire logic       motorPhaseB,
  output wire logic       motorPhaseC,
  output wire logic       headLoadOut,
  input  wire logic       headEngagedInN
);

  fhs_state_s  st_q;
  fhs_state_s  st_d;
  fhs_pins_s   pinsIn;
  logic        rdAct;
  logic        wrAct;
  logic        rdStart;
  logic        wrStart;
  logic        tick;
  logic        idx;
  logic        byteDone;
  logic        typeI;
  logic        restore;
  logic        wantStep;
  logic        done;
  logic [7:0]  newByte;
  logic [15:0] crcNew;

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic b);
    crcStep = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `FHS_CRC_POLY : 16'h0000);
  endfunction : crcStep

  function automatic logic [21:0] stepCycles(input logic [1:0] rate, input logic test);
    if (!test) begin
      stepCycles = 22'(StepCycTest);
    end else begin
      case (rate)
        2'h0, 2'h1: stepCycles = 22'(StepCyc6);
        2'h2:       stepCycles = 22'(StepCyc10);
        default:    stepCycles = 22'(StepCyc20);
      endcase
    end
  endfunction : stepCycles

  function automatic logic [7:0] statusByte(input fhs_state_s s);
    statusByte = 8'h00;
    statusByte[`FHS_ST_BUSY] = s.busy;
    statusByte[`FHS_ST_CRC]  = s.crcErr;
    if (!s.cmd[7]) begin
      statusByte[`FHS_ST_INDEX] = s.s2.index;
      statusByte[`FHS_ST_TRK0]  = !s.s2.trackZeroN;
      statusByte[`FHS_ST_SEEK]  = s.seekErr;
      statusByte[`FHS_ST_HEAD]  = s.headLoad;
    end else begin
      statusByte[`FHS_ST_DRQ]  = s.byte_request;
      statusByte[`FHS_ST_LOST] = s.lost;
    end
  endfunction : statusByte

  assign pinsIn = '{csN: chipSelectN, rdN: readStrobeN, wrN: writeStrobeN,
                    sel: regSelect, data: hostBusLinesIn, tick: diskBitTick,
                    rdat: diskReadSerial, index: indexPulse, motorType: motorTypeSel,
                    test: testStrap, engagedN: headEngagedInN, trackZeroN: trackZeroN};

  always_comb begin
    st_d     = st_q;
    rdAct    = !st_q.s2.csN && !st_q.s2.rdN;
    wrAct    = !st_q.s2.csN && !st_q.s2.wrN;
    rdStart  = rdAct && (st_q.prev.csN || st_q.prev.rdN);
    wrStart  = wrAct && (st_q.prev.csN || st_q.prev.wrN);
    tick     = st_q.s2.tick && !st_q.prev.tick;
    idx      = st_q.s2.index && !st_q.prev.index;
    newByte  = {st_q.shift[6:0], st_q.s2.rdat};
    crcNew   = crcStep(st_q.crc, st_q.s2.rdat);
    byteDone = tick && (st_q.bitCnt == 3'h7);
    typeI    = !st_q.cmd[7];
    restore  = st_q.cmd[7:4] == `FHS_CMD_RESTORE;
    done     = 1'b0;
    case (st_q.cmd[7:4])
      `FHS_CMD_RESTORE: wantStep = st_q.s2.trackZeroN;
      `FHS_CMD_SEEK:    wantStep = st_q.track != st_q.data;
      default:          wantStep = st_q.stepCnt == 8'h00;
    endcase

    // pins pass two flops, third copy is for edges
    st_d.s1   = pinsIn;
    st_d.s2   = st_q.s1;
    st_d.prev = st_q.s2;
    st_d.cnt  = st_q.cnt + 22'h1;

    st_d.busOe = rdAct;
    case (st_q.s2.sel)
      `FHS_REG_CMD_STAT: st_d.busOut = statusByte(st_q);
      `FHS_REG_TRACK:    st_d.busOut = st_q.track;
      `FHS_REG_SECTOR:   st_d.busOut = st_q.sector;
      default:           st_d.busOut = st_q.data;
    endcase

    if (rdStart && st_q.s2.sel == `FHS_REG_CMD_STAT) begin
      st_d.irq = 1'b0;
    end
    if (rdStart && st_q.s2.sel == `FHS_REG_DATA) begin
      st_d.byte_request = 1'b0;
    end
    if (wrStart) begin
      case (st_q.s2.sel)
        `FHS_REG_TRACK:  st_d.track = st_q.s2.data;
        `FHS_REG_SECTOR: st_d.sector = st_q.s2.data;
        `FHS_REG_DATA: begin
          st_d.data = st_q.s2.data;
          st_d.byte_request  = 1'b0;
        end
        default: ;
      endcase
    end
    if (idx && st_q.idxArm) begin
      st_d.irq    = 1'b1;
      st_d.idxArm = 1'b0;
    end
    // head drops on the third index with no command running
    if (idx && st_q.headLoad && !st_q.busy) begin
      st_d.unloadIdx = st_q.unloadIdx + 2'h1;
      if (st_q.unloadIdx == `FHS_UNLOAD_IDX - 2'h1) begin
        st_d.headLoad = 1'b0;
      end
    end

    if (wrStart && st_q.s2.sel == `FHS_REG_CMD_STAT) begin
      st_d.cmd       = st_q.s2.data;
      st_d.cnt       = 22'h0;
      st_d.state     = ST_IDLE;
      st_d.stepPulse = 1'b0;
      st_d.idxArm    = 1'b0;
      st_d.unloadIdx = 2'h0;
      st_d.irq       = st_q.busy;
      if (st_q.s2.data[7:4] == `FHS_CMD_FORCE) begin
        st_d.busy   = 1'b0;
        st_d.byte_request    = 1'b0;
        st_d.irq    = st_q.busy || st_q.s2.data[`FHS_CMD_IMMED];
        st_d.idxArm = st_q.s2.data[`FHS_CMD_ONINDEX];
      end else if (!st_q.s2.data[7]) begin
        st_d.busy     = 1'b1;
        st_d.seekErr  = 1'b0;
        st_d.crcErr   = 1'b0;
        st_d.lost     = 1'b0;
        st_d.byte_request      = 1'b0;
        st_d.stepCnt  = 8'h00;
        st_d.headLoad = st_q.s2.data[`FHS_CMD_HEADLD];
        if (st_q.s2.data[6:5] == 2'h2) begin
          st_d.dirIn = 1'b1;
        end else if (st_q.s2.data[6:5] == 2'h3 || st_q.s2.data[6:4] == 3'h0) begin
          st_d.dirIn = 1'b0;
        end
      end else if (!st_q.s2.data[6]) begin
        st_d.busy      = 1'b1;
        st_d.seekErr   = 1'b0;
        st_d.crcErr    = 1'b0;
        st_d.lost      = 1'b0;
        st_d.bitCnt    = 3'h0;
        st_d.byteCnt   = 8'h00;
        st_d.wrStarted = 1'b0;
        if (st_q.s2.data[`FHS_CMD_ENGAGE]) begin
          st_d.headLoad = 1'b1;
          st_d.byte_request      = 1'b0;
          st_d.state    = ST_HLD;
        end else begin
          st_d.byte_request   = st_q.s2.data[`FHS_CMD_WRITE];
          st_d.state = ST_XFER;
        end
      end else begin
        st_d.busy = 1'b0;
        st_d.irq  = 1'b1;
      end
    end else begin
      case (st_q.state)
        ST_IDLE: begin
          if (st_q.busy && typeI) begin
            if (wantStep && !(restore && st_q.stepCnt == `FHS_RESTORE_MAX)) begin
              if (st_q.cmd[7:4] == `FHS_CMD_SEEK) begin
                st_d.dirIn = st_q.data > st_q.track;
              end
              st_d.state = ST_DIR;
              st_d.cnt   = 22'h0;
            end else begin
              if (restore && st_q.s2.trackZeroN) begin
                st_d.seekErr = 1'b1;
              end else if (restore) begin
                st_d.track = `FHS_RST_TRACK;
              end
              st_d.state = ST_SETTLE;
              st_d.cnt   = 22'h0;
            end
          end
        end
        ST_DIR: begin
          if (st_q.cnt == 22'(`FHS_CYC_DIR_SETUP - 1)) begin
            st_d.state     = ST_PULSE;
            st_d.cnt       = 22'h0;
            st_d.stepPulse = 1'b1;
            st_d.stepCnt   = st_q.stepCnt + 8'h01;
            if (st_q.dirIn) begin
              st_d.phase = (st_q.phase == 2'h2) ? 2'h0 : st_q.phase + 2'h1;
            end else begin
              st_d.phase = (st_q.phase == 2'h0) ? 2'h2 : st_q.phase - 2'h1;
            end
            if (st_q.cmd[7:5] == 3'h0 || st_q.cmd[`FHS_CMD_UPDATE]) begin
              st_d.track = st_q.dirIn ? st_q.track + 8'h01 : st_q.track - 8'h01;
            end
          end
        end
        ST_PULSE: begin
          if (st_q.cnt == 22'(`FHS_CYC_STEP_PULSE - 1)) begin
            st_d.stepPulse = 1'b0;
            st_d.state     = ST_WAIT;
            st_d.cnt       = 22'h0;
          end
        end
        ST_WAIT: begin
          if (st_q.cnt == stepCycles(st_q.cmd[1:0], st_q.s2.test) - 22'h1) begin
            st_d.state = ST_IDLE;
          end
        end
        ST_SETTLE: begin
          if (st_q.cnt == 22'(SettleCyc - 1)) begin
            if (st_q.cmd[`FHS_CMD_VERIFY]) begin
              st_d.headLoad = 1'b1;
              st_d.state    = ST_HLD;
              st_d.cnt      = 22'h0;
            end else begin
              done = 1'b1;
            end
          end
        end
        ST_HLD: begin
          if (st_q.cnt >= 22'(HeadCyc - 1)) begin
            st_d.cnt = st_q.cnt;
            if (!st_q.s2.engagedN) begin
              st_d.state     = typeI ? ST_VERIFY : ST_XFER;
              st_d.bitCnt    = 3'h0;
              st_d.byteCnt   = 8'h00;
              st_d.crc       = `FHS_CRC_PRESET;
              st_d.verIdx    = 2'h0;
              st_d.wrStarted = 1'b0;
              st_d.byte_request       = !typeI && st_q.cmd[`FHS_CMD_WRITE];
            end
          end
        end
        ST_VERIFY: begin
          if (tick) begin
            st_d.shift  = newByte;
            st_d.bitCnt = st_q.bitCnt + 3'h1;
            st_d.crc    = crcNew;
          end
          if (byteDone) begin
            st_d.byteCnt = st_q.byteCnt + 8'h01;
            if (st_q.byteCnt == `FHS_ID_TRACK_POS) begin
              st_d.idMatch = newByte == st_q.track;
            end
            if (st_q.byteCnt == `FHS_ID_BYTES - 8'h01) begin
              if (crcNew == 16'h0000) begin
                st_d.seekErr = !st_q.idMatch;
                done         = 1'b1;
              end else begin
                st_d.crcErr  = 1'b1;
                st_d.byteCnt = 8'h00;
                st_d.crc     = `FHS_CRC_PRESET;
              end
            end
          end
          if (idx) begin
            st_d.verIdx = st_q.verIdx + 2'h1;
            if (st_q.verIdx == `FHS_VERIFY_IDX - 2'h1) begin
              done = 1'b1;
            end
          end
        end
        ST_XFER: begin
          if (!st_q.cmd[`FHS_CMD_WRITE]) begin
            if (tick) begin
              st_d.shift  = newByte;
              st_d.bitCnt = st_q.bitCnt + 3'h1;
            end
            if (byteDone) begin
              if (st_q.byte_request) begin
                st_d.lost = 1'b1;
                st_d.irq  = 1'b1;
              end
              st_d.data    = newByte;
              st_d.byte_request     = 1'b1;
              st_d.byteCnt = st_q.byteCnt + 8'h01;
              if (st_q.byteCnt == `FHS_SECTOR_BYTES - 8'h01) begin
                done = 1'b1;
              end
            end
          end else if (!st_q.wrStarted) begin
            // nothing goes to the disk before the first byte is loaded
            if (!st_q.byte_request) begin
              st_d.wrStarted = 1'b1;
              st_d.shift     = st_q.data;
              st_d.byte_request       = 1'b1;
            end
          end else if (tick) begin
            st_d.wrBit  = st_q.shift[7];
            st_d.shift  = {st_q.shift[6:0], 1'b0};
            st_d.bitCnt = st_q.bitCnt + 3'h1;
            if (st_q.bitCnt == 3'h7) begin
              st_d.byteCnt = st_q.byteCnt + 8'h01;
              if (st_q.byteCnt == `FHS_SECTOR_BYTES - 8'h01) begin
                done = 1'b1;
              end else begin
                if (st_q.byte_request) begin
                  st_d.shift = 8'h00;
                  st_d.lost  = 1'b1;
                  st_d.irq   = 1'b1;
                end else begin
                  st_d.shift = st_q.data;
                end
                st_d.byte_request = 1'b1;
              end
            end
          end
        end
        default: st_d.state = ST_IDLE;
      endcase
      if (done) begin
        st_d.busy      = 1'b0;
        st_d.irq       = 1'b1;
        st_d.state     = ST_IDLE;
        st_d.unloadIdx = 2'h0;
      end
    end

    if (!st_q.s2.motorType) begin
      st_d.phA = st_d.phase != 2'h0;
      st_d.phB = st_d.phase != 2'h1;
      st_d.phC = st_d.phase != 2'h2;
    end else begin
      st_d.phA = !st_d.stepPulse;
      st_d.phB = st_d.dirIn;
      st_d.phC = 1'b1;
    end

    if (sys_rst) begin
      st_d      = '0;
      st_d.s1   = '1;
      st_d.s2   = '1;
      st_d.prev = '1;
      // mode pin reads three-phase until synced, so phase one holds after reset
      st_d.s1.motorType = 1'b0;
      st_d.s2.motorType = 1'b0;
      st_d.crc  = `FHS_CRC_PRESET;
      st_d.phB  = 1'b1;
      st_d.phC  = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    st_q <= st_d;
  end

  assign hostBusLinesOut = st_q.busOut;
  assign hostBusLinesOe  = st_q.busOe;
  assign byteRequest     = st_q.byte_request;
  assign irqOut          = st_q.irq;
  assign diskWriteSerial = st_q.wrBit;
  assign motorPhaseA     = st_q.phA;
  assign motorPhaseB     = st_q.phB;
  assign motorPhaseC     = st_q.phC;
  assign headLoadOut     = st_q.headLoad;

endmodule : fhs_top

/* File: dv/fhs_drive_model.sv */
module fhs_drive_model #(
  parameter int StartPos  = 3,
  parameter int IdxPeriod = 2000
) (
  input  wire logic clk_sys,
  input  wire logic motorTypeSel,
  input  wire logic motorPhaseA,
  input  wire logic motorPhaseB,
  input  wire logic motorPhaseC,
  input  wire logic headLoadOut,
  output logic      trackZeroN,
  output logic      indexPulse,
  output logic      headEngagedInN,
  output int        pos
);
  timeunit 1ns;
  timeprecision 1ns;
  int last = 0;
  int idxCnt = 0;
  int engCnt = 0;
  int cur;
  initial pos = StartPos;
  always_comb cur = !motorPhaseA ? 0 : (!motorPhaseB ? 1 : (!motorPhaseC ? 2 : last));
  // arm follows the active phase, reverse order moves outward
  always @(posedge clk_sys) begin
    if (!motorTypeSel && cur != last) pos <= pos + ((cur == (last + 1) % 3) ? 1 : -1);
    last   <= cur;
    idxCnt <= (idxCnt + 1) % IdxPeriod;
    engCnt <= headLoadOut ? engCnt + 1 : 0;
  end
  assign trackZeroN     = (pos != 0);
  assign indexPulse     = (idxCnt < 20);
  assign headEngagedInN = !(engCnt > 600);
endmodule : fhs_drive_model

/* File: dv/fhs_top_checker.sv */
module fhs_top_checker (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       chipSelectN,
  input wire logic       readStrobeN,
  input wire logic       writeStrobeN,
  input wire logic [1:0] regSelect,
  input wire logic       hostBusLinesOe,
  input wire logic       byteRequest,
  input wire logic       irqOut,
  input wire logic       motorTypeSel,
  input wire logic       motorPhaseA,
  input wire logic       motorPhaseB,
  input wire logic       motorPhaseC
);
  logic [11:0] dirCnt;
  logic [9:0]  lowCnt;
  logic        prevB;
  logic        regZero;
  assign regZero = !chipSelectN && regSelect == 2'h0 && !(readStrobeN && writeStrobeN);
  always_ff @(posedge clk_sys) begin
    prevB  <= motorPhaseB;
    dirCnt <= sys_rst ? 12'hFFF : (motorPhaseB != prevB) ? 12'h001 : (dirCnt == 12'hFFF) ? dirCnt : dirCnt + 12'h001;
    lowCnt <= (sys_rst || motorPhaseA) ? 10'h000 : (lowCnt == 10'h3FF) ? lowCnt : lowCnt + 10'h001;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_read_held;
    (!chipSelectN && !readStrobeN) [*4];
  endsequence
  sequence s_step_start;
    motorTypeSel && $fell(motorPhaseA);
  endsequence
  a_oe_only_read: assert property (hostBusLinesOe |-> $past(!chipSelectN && !readStrobeN, 3))
    else $error("bus driven without read");
  a_oe_on_read: assert property (s_read_held |=> hostBusLinesOe)
    else $error("bus not driven on read");
  a_irq_holds: assert property ($fell(irqOut) && !$past(sys_rst) |-> $past(regZero, 3))
    else $error("irq dropped without access");
  a_req_holds: assert property ($fell(byteRequest) && !$past(sys_rst)
    |-> $past(!chipSelectN && !(readStrobeN && writeStrobeN), 3))
    else $error("request dropped without access");
  a_phase_reset: assert property ($fell(sys_rst) |-> !motorPhaseA && motorPhaseB && motorPhaseC)
    else $error("phase one not active after reset");
  a_one_phase: assert property (!motorTypeSel && !$past(motorTypeSel, 3)
    |-> $onehot({!motorPhaseA, !motorPhaseB, !motorPhaseC}))
    else $error("not exactly one phase active");
  a_dir_setup: assert property (s_step_start |-> dirCnt >= 12'h960)
    else $error("direction setup too short");
  a_step_width: assert property ($rose(motorPhaseA) && $past(motorTypeSel, 200) |-> lowCnt == 10'h190)
    else $error("step pulse width wrong");
endmodule : fhs_top_checker

bind fhs_top fhs_top_checker u_fhs_top_checker (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .chipSelectN(chipSelectN), .readStrobeN(readStrobeN),
  .writeStrobeN(writeStrobeN), .regSelect(regSelect), .hostBusLinesOe(hostBusLinesOe),
  .byteRequest(byteRequest), .irqOut(irqOut), .motorTypeSel(motorTypeSel),
  .motorPhaseA(motorPhaseA), .motorPhaseB(motorPhaseB), .motorPhaseC(motorPhaseC)
);

/* File: dv/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int Settle = 500;
  localparam int Rates [4] = '{1000, 1000, 2000, 3000};
  logic       clk_sys = 1'b0, sys_rst = 1'b1, csN = 1'b1, rdN = 1'b1, wrN = 1'b1;
  logic       typeSel = 1'b0, strap = 1'b1, busOe, byteReq, irq, phA, phB, phC, headLd, trk0N, idx, engN;
  logic       rBit = 1'b0, bitTick = 1'b0, wBit;
  logic [1:0] regSel = 2'h0;
  logic [7:0] hostData = 8'h00, busOut, trk;
  wire  [7:0] busWire = busOe ? busOut : hostData;
  int         pos, ph, nFail = 0, nChecks = 0;
  always #5 clk_sys = ~clk_sys;
  fhs_top #(.StepCyc6(1000), .StepCyc10(2000), .StepCyc20(3000), .StepCycTest(1500), .SettleCyc(Settle),
    .HeadCyc(500)) u_fhs_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .chipSelectN(csN), .readStrobeN(rdN),
    .writeStrobeN(wrN), .regSelect(regSel), .hostBusLinesIn(busWire), .hostBusLinesOut(busOut),
    .hostBusLinesOe(busOe), .byteRequest(byteReq), .irqOut(irq), .diskReadSerial(rBit), .diskBitTick(bitTick),
    .diskWriteSerial(wBit), .indexPulse(idx), .trackZeroN(trk0N), .motorTypeSel(typeSel), .testStrap(strap),
    .motorPhaseA(phA), .motorPhaseB(phB), .motorPhaseC(phC), .headLoadOut(headLd), .headEngagedInN(engN));
  fhs_drive_model u_fhs_drive_model (.clk_sys(clk_sys),
    .motorTypeSel(typeSel), .motorPhaseA(phA), .motorPhaseB(phB), .motorPhaseC(phC), .headLoadOut(headLd),
    .trackZeroN(trk0N), .indexPulse(idx), .headEngagedInN(engN), .pos(pos));
  task automatic wrapUp;
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrapUp
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    nChecks++;
    if (got !== exp) begin
      nFail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chkNear(input int got, input int exp, input string what);
    nChecks++;
    if (got < exp - 12 || got > exp + 12) begin
      nFail++;
      $display("CHECK FAILED t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : chkNear
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic sendBit(input logic b);
    rBit = b;
    bitTick = 1'b1;
    cyc(2);
    bitTick = 1'b0;
    cyc(3);
  endtask : sendBit
  // strobes held and released four cycles, bus sampled after the 3-edge lag
  task automatic acc(input logic rd, input logic [1:0] s, input logic [7:0] d, output logic [7:0] q);
    csN = 1'b0;
    rdN = !rd;
    wrN = rd;
    regSel = s;
    hostData = d;
    cyc(4);
    q = busOut;
    chk({7'h00, busOe}, {7'h00, rd}, "bus enable");
    csN = 1'b1;
    rdN = 1'b1;
    wrN = 1'b1;
    hostData = ~d;
    cyc(4);
    chk({7'h00, busOe}, 8'h00, "bus released");
  endtask : acc
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b0, s, d, q);
  endtask : wr
  task automatic rdc(input logic [1:0] s, input logic [7:0] m, input logic [7:0] e, input string w);
    logic [7:0] q;
    acc(1'b1, s, 8'h00, q);
    chk(q & m, e, w);
  endtask : rdc
  task automatic waitIrq(output int n);
    n = 0;
    while (irq !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 40000) begin
        nFail++;
        $display("CHECK FAILED t=%0t irq wait timed out", $time);
        wrapUp();
      end
    end
  endtask : waitIrq
  task automatic tRegs;
    rdc(2'h1, 8'hFF, 8'h00, "track reset");
    wr(2'h2, 8'h5A);
    wr(2'h3, 8'hC3);
    wr(2'h1, 8'h05);
    rdc(2'h2, 8'hFF, 8'h5A, "sector");
    rdc(2'h3, 8'hFF, 8'hC3, "data");
    rdc(2'h1, 8'hFF, 8'h05, "track");
    rdc(2'h0, 8'h01, 8'h00, "idle status");
    trk = 8'h05;
  endtask : tRegs
  task automatic tStep(input logic [7:0] c, input int rate, input int dt);
    int n;
    wr(2'h0, c);
    waitIrq(n);
    chkNear(n, 2797 + rate + Settle, "step time");
    ph = (ph + (dt > 0 ? 1 : 2)) % 3;
    trk = trk + dt;
    chk({5'h00, phA, phB, phC}, ph == 0 ? 8'h03 : (ph == 1 ? 8'h05 : 8'h06), "phase");
    rdc(2'h1, 8'hFF, trk, "stepped track");
    rdc(2'h0, 8'h01, 8'h00, "busy");
    chk({7'h00, irq}, 8'h00, "irq cleared");
  endtask : tStep
  task automatic tRestoreSeek;
    int n;
    ph = (ph + 2 * pos) % 3;
    wr(2'h0, 8'h00);
    waitIrq(n);
    rdc(2'h1, 8'hFF, 8'h00, "restored track");
    rdc(2'h0, 8'h15, 8'h04, "track zero status");
    chk(pos[7:0], 8'h00, "drive at zero");
    wr(2'h3, 8'h02);
    wr(2'h0, 8'h10);
    waitIrq(n);
    ph = (ph + 2) % 3;
    rdc(2'h1, 8'hFF, 8'h02, "seek track");
    chk(pos[7:0], 8'h02, "drive at target");
    trk = 8'h02;
  endtask : tRestoreSeek
  task automatic tAbort;
    int n;
    wr(2'h0, 8'h50);
    cyc(100);
    wr(2'h0, 8'hD8);
    waitIrq(n);
    chkNear(n, 0, "abort irq");
    cyc(6000);
    rdc(2'h1, 8'hFF, 8'h02, "aborted track");
    rdc(2'h0, 8'h01, 8'h00, "idle after abort");
  endtask : tAbort
  task automatic tRead;
    wr(2'h0, 8'h80);
    for (int i = 7; i >= 0; i--) sendBit(i[0]);
    chk({7'h00, byteReq}, 8'h01, "read request");
    rdc(2'h3, 8'hFF, 8'hAA, "read byte");
    chk({7'h00, byteReq}, 8'h00, "request cleared");
    repeat (16) sendBit(1'b1);
    rdc(2'h0, 8'h07, 8'h07, "lost data status");
    wr(2'h0, 8'hD0);
  endtask : tRead
  task automatic tWriteReq;
    wr(2'h0, 8'hA0);
    chk({7'h00, byteReq}, 8'h01, "write request");
    rdc(2'h0, 8'h03, 8'h03, "request status");
    wr(2'h3, 8'hB7);
    chk({7'h00, byteReq}, 8'h01, "request again");
    sendBit(1'b0);
    chk({7'h00, wBit}, 8'h01, "write bit 7");
    sendBit(1'b0);
    chk({7'h00, wBit}, 8'h00, "write bit 6");
    wr(2'h0, 8'hD8);
    chk({7'h00, irq}, 8'h01, "force irq");
    rdc(2'h0, 8'h01, 8'h00, "write aborted");
  endtask : tWriteReq
  task automatic tHeadOff;
    int k;
    int n;
    logic pr;
    k = 0;
    n = 0;
    pr = idx;
    chk({7'h00, headLd}, 8'h01, "head loaded");
    while (headLd === 1'b1 && n < 10000) begin
      cyc(1);
      n++;
      if (idx && !pr) k++;
      pr = idx;
    end
    chkNear(k * 20, 60, "index count to unload");
    chk({7'h00, headLd}, 8'h00, "head unloaded");
  endtask : tHeadOff
  task automatic tStepDir;
    int n;
    typeSel = 1'b1;
    cyc(10);
    wr(2'h0, 8'h40);
    waitIrq(n);
    chk({6'h00, phB, phC}, 8'h03, "direction in");
    wr(2'h0, 8'h60);
    waitIrq(n);
    chk({6'h00, phB, phC}, 8'h01, "direction out");
  endtask : tStepDir
  initial begin
    ph = 0;
    cyc(2);
    sys_rst = 1'b0;
    cyc(1);
    tRegs();
    for (int r = 0; r < 4; r++) tStep(8'h50 | r[7:0], Rates[r], 1);
    strap = 1'b0;
    cyc(4);
    tStep(8'h53, 1500, 1);
    strap = 1'b1;
    cyc(4);
    tStep(8'h70, 1000, -1);
    tRestoreSeek();
    tAbort();
    tRead();
    tWriteReq();
    tStep(8'h58, 1000, 1);
    tHeadOff();
    tStepDir();
    wrapUp();
  end
endmodule : tb_top
